/* hdl/i2cc_regs.vh */
`ifndef I2CC_REGS_VH
`define I2CC_REGS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define I2CC_CON 8'h00
`define I2CC_STAT 8'h04
`define I2CC_MSK 8'h08
`define I2CC_TRN 8'h0c
`define I2CC_RCV 8'h10
`define I2CC_ADD 8'h14
`define I2CC_BRG 8'h18
// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define I2CC_EN 15
`define I2CC_REL 12
`define I2CC_ACC 11
`define I2CC_A10 10
`define I2CC_GCE 7
`define I2CC_STR 6
`define I2CC_AKV 5
`define I2CC_AKS 4
`define I2CC_RXE 3
`define I2CC_STP 2
`define I2CC_RSR 1
`define I2CC_STA 0
// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define I2CC_ACKST 15
`define I2CC_TRST 14
`define I2CC_BCL 10
`define I2CC_GCST 9
`define I2CC_TEN_BIT_MATCH 8
`define I2CC_WRITE_COLLISION 7
`define I2CC_ROV 6
`define I2CC_DA 5
`define I2CC_PS 4
`define I2CC_SS 3
`define I2CC_RW 2
`define I2CC_RBF 1
`define I2CC_TBF 0
// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define I2CC_CON_RST 16'h1000
`define I2CC_CON_WMASK 16'hbfff
`define I2CC_BRG_RST 16'h0031
`define I2CC_GC_ADDR 8'h00
`define I2CC_HDR10 5'h1e
`endif

/* hdl/i2cc_ctrl.v */
`include "i2cc_regs.vh"
`default_nettype none
// Functional notes
// RQ1 - Clear release holds clock low as slave
// RQ2 - Release writable; cleared at slave transmit start
// RQ3 - Accept-all mode acknowledges every address
// RQ4 - Width select picks 10-bit or 7-bit address
// RQ5 - General call acknowledged when enabled, and also in accept-all mode or on an own-address match
// RQ6 - Acknowledge sequence sends chosen value, self-clears
// RQ7 - Receive enable takes one byte, self-clears
// RQ8 - Stop request makes Stop, self-clears
// RQ9 - Repeated start request makes it, self-clears
// RQ10 - Start request makes Start, self-clears
// RQ11 - Ack status updated after slave acknowledge
// RQ12 - Transmit busy across eight bits plus ack
// RQ13 - Collision sets sticky flag until software clears
// RQ14 - General call flag set on match, Stop clears
// RQ15 - Ten-bit match on second byte, Stop clears
// RQ16 - Transmit write while busy fails, flags collision
// RQ17 - Byte into full holding register flags overflow
// RQ18 - Data/address flag: clear on match, set data
// RQ19 - Read/write flag taken from address byte
// RQ20 - Start-seen and stop-seen show last condition
// RQ21 - Receive full and transmit full flag tracking
// RQ22 - Mask bits exempt address bits from matching
// RQ23 - Software issues one master sequence at a time
module i2cc_ctrl (
  input wire mclk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o
);
  localparam M_IDLE = 3'd0;
  localparam M_START = 3'd1;
  localparam M_RSTRT = 3'd2;
  localparam M_STOP = 3'd3;
  localparam M_BIT = 3'd4;
  localparam MD_TX = 2'd0;
  localparam MD_RX = 2'd1;
  localparam MD_ACK = 2'd2;
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ADR2 = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_ACK = 3'd4;
  localparam S_TX = 3'd5;

  reg [15:0] con;
  reg [9:0] msk;
  reg [9:0] own;
  reg [15:0] brg;
  reg [7:0] trn;
  reg [7:0] rcv;
  reg ackst, trst, bus_collision, gcst, ten_bit_match, write_collision, rov;
  reg d_a, p_seen, s_seen, r_w, receive_full, transmit_full;
  reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  reg [2:0] mst;
  reg [1:0] q;
  reg [1:0] mmode;
  reg [3:0] mbit;
  reg [7:0] msh;
  reg [15:0] mcnt;
  reg m_sda, m_scl, is_mst;
  reg [2:0] sst;
  reg [2:0] snext;
  reg [3:0] bcnt;
  reg [7:0] rsr;
  reg s_sda, s_scl, mack;
  reg [15:0] stat_w;
  reg [31:0] rdv;

  // ----------------------------------------------------------------
  // Bus conditions and APB decode
  // ----------------------------------------------------------------
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
  wire s_rise = scl_s & ~scl_p;
  wire s_fall = ~scl_s & scl_p;
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire rd = acc & ~pwrite_i;
  wire hit = (paddr_i == `I2CC_CON) | (paddr_i == `I2CC_STAT) |
             (paddr_i == `I2CC_MSK) | (paddr_i == `I2CC_TRN) |
             (paddr_i == `I2CC_RCV) | (paddr_i == `I2CC_ADD) |
             (paddr_i == `I2CC_BRG);
  wire busy = (mst != M_IDLE) | transmit_full | (con[4:0] != 5'h00);
  // Waiting for a stretched clock freezes the quarter-bit timer
  wire stall = (mst != M_IDLE) & (q == 2'd2) & ~scl_s & ~m_scl;
  wire tick = (mcnt == brg) & ~stall;
  wire bitv = (mmode == MD_TX) ? ((mbit == 4'd8) | msh[7]) :
              (mmode == MD_RX) ? 1'b1 : con[`I2CC_AKV];
  wire [3:0] mlast = (mmode == MD_TX) ? 4'd8 :
                     (mmode == MD_RX) ? 4'd7 : 4'd0;
  wire gc_hit = con[`I2CC_GCE] & (rsr == `I2CC_GC_ADDR); // [RQ5]
  wire hit7 = ~con[`I2CC_A10] &
              (((rsr[7:1] ^ own[6:0]) & ~msk[6:0]) == 7'h00); // [RQ22]
  wire hdr10 = con[`I2CC_A10] & (rsr[7:3] == `I2CC_HDR10) &
               (((rsr[2:1] ^ own[9:8]) & ~msk[9:8]) == 2'h0); // [RQ4]
  wire hit10 = ((rsr ^ own[7:0]) & ~msk[7:0]) == 8'h00; // [RQ22]
  wire adr_ok = con[`I2CC_ACC] | gc_hit | hit7 |
                (hdr10 & (~rsr[0] | ten_bit_match)); // [RQ3]

  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = m_scl | s_scl; // [RQ1]
  assign sda_oe_o = m_sda | s_sda;

  always @*
  begin
    stat_w = 16'h0000;
    stat_w[`I2CC_ACKST] = ackst;
    stat_w[`I2CC_TRST] = trst;
    stat_w[`I2CC_BCL] = bus_collision;
    stat_w[`I2CC_GCST] = gcst;
    stat_w[`I2CC_TEN_BIT_MATCH] = ten_bit_match;
    stat_w[`I2CC_WRITE_COLLISION] = write_collision;
    stat_w[`I2CC_ROV] = rov;
    stat_w[`I2CC_DA] = d_a;
    stat_w[`I2CC_PS] = p_seen;
    stat_w[`I2CC_SS] = s_seen;
    stat_w[`I2CC_RW] = r_w;
    stat_w[`I2CC_RBF] = receive_full;
    stat_w[`I2CC_TBF] = transmit_full;
  end

  always @*
  begin
    case (paddr_i)
      `I2CC_CON: rdv = {16'h0000, con};
      `I2CC_STAT: rdv = {16'h0000, stat_w};
      `I2CC_MSK: rdv = {22'h00_0000, msk};
      `I2CC_TRN: rdv = {24'h00_0000, trn};
      `I2CC_RCV: rdv = {24'h00_0000, rcv};
      `I2CC_ADD: rdv = {22'h00_0000, own};
      `I2CC_BRG: rdv = {16'h0000, brg};
      default: rdv = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Registers, master sequencer and slave engine
  // ----------------------------------------------------------------
  // Software clears come first so a same-cycle hardware set wins
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      con <= `I2CC_CON_RST;
      msk <= 10'h000;
      own <= 10'h000;
      brg <= `I2CC_BRG_RST;
      trn <= 8'h00;
      rcv <= 8'h00;
      {ackst, trst, bus_collision, gcst, ten_bit_match, write_collision, rov} <= 7'h00;
      {d_a, p_seen, s_seen, r_w, receive_full, transmit_full} <= 6'h00;
      prdata_o <= 32'h0000_0000;
      mst <= M_IDLE;
      q <= 2'd0;
      mmode <= MD_TX;
      mbit <= 4'd0;
      msh <= 8'h00;
      mcnt <= 16'h0000;
      {m_sda, m_scl, is_mst} <= 3'b000;
      sst <= S_IDLE;
      snext <= S_IDLE;
      bcnt <= 4'd0;
      rsr <= 8'h00;
      {s_sda, s_scl, mack} <= 3'b000;
    end
    else
    begin
      if (psel_i & ~penable_i)
        prdata_o <= rdv;
      if (wr & (paddr_i == `I2CC_STAT))
      begin
        if (~pwdata_i[`I2CC_BCL])
          bus_collision <= 1'b0;
        if (~pwdata_i[`I2CC_WRITE_COLLISION])
          write_collision <= 1'b0;
        if (~pwdata_i[`I2CC_ROV])
          rov <= 1'b0;
      end
      if (rd & (paddr_i == `I2CC_RCV))
        receive_full <= 1'b0; // [RQ21]
      if (start_det)
      begin
        s_seen <= 1'b1; // [RQ20]
        p_seen <= 1'b0;
      end
      if (stop_det)
      begin
        p_seen <= 1'b1; // [RQ20]
        s_seen <= 1'b0;
        gcst <= 1'b0; // [RQ14]
        ten_bit_match <= 1'b0; // [RQ15]
      end
      mcnt <= (mst == M_IDLE || tick) ? 16'h0000 :
              (stall ? mcnt : mcnt + 16'h0001);
      if (~con[`I2CC_EN])
      begin
        mst <= M_IDLE;
        sst <= S_IDLE;
        {m_sda, m_scl, is_mst, s_sda, s_scl} <= 5'h00;
      end
      else
      begin
        if (mst == M_IDLE)
        begin
          q <= 2'd0;
          mbit <= 4'd0;
          if (con[`I2CC_STA])
          begin
            if (~scl_s | ~sda_s)
            begin
              bus_collision <= 1'b1; // [RQ13]
              con[`I2CC_STA] <= 1'b0;
            end
            else
              mst <= M_START;
          end
          else if (con[`I2CC_RSR])
            mst <= M_RSTRT;
          else if (con[`I2CC_STP])
            mst <= M_STOP;
          else if (con[`I2CC_RXE])
          begin
            mst <= M_BIT; // [RQ7]
            mmode <= MD_RX;
          end
          else if (con[`I2CC_AKS])
          begin
            mst <= M_BIT; // [RQ6]
            mmode <= MD_ACK;
          end
        end
        else if (tick)
        begin
          q <= q + 2'd1;
          case (mst)
            M_START:
              if (q == 2'd0)
                m_sda <= 1'b1; // [RQ10]
              else
              begin
                m_scl <= 1'b1;
                con[`I2CC_STA] <= 1'b0; // [RQ10]
                is_mst <= 1'b1;
                mst <= M_IDLE;
              end
            M_RSTRT:
              case (q)
                2'd0: m_sda <= 1'b0; // [RQ9]
                2'd1: m_scl <= 1'b0;
                2'd2: m_sda <= 1'b1;
                default:
                begin
                  m_scl <= 1'b1;
                  con[`I2CC_RSR] <= 1'b0; // [RQ9]
                  is_mst <= 1'b1;
                  mst <= M_IDLE;
                end
              endcase
            M_STOP:
              case (q)
                2'd0: m_sda <= 1'b1; // [RQ8]
                2'd1: m_scl <= 1'b0;
                default:
                begin
                  m_sda <= 1'b0;
                  con[`I2CC_STP] <= 1'b0; // [RQ8]
                  is_mst <= 1'b0;
                  mst <= M_IDLE;
                end
              endcase
            M_BIT:
              case (q)
                2'd0: m_sda <= ~bitv; // [RQ6]
                2'd1: m_scl <= 1'b0;
                2'd2:
                begin
                  msh <= {msh[6:0], sda_s};
                  // Lost arbitration: we released data, someone pulled
                  if (mmode == MD_TX && mbit < 4'd8 && ~m_sda && ~sda_s)
                  begin
                    bus_collision <= 1'b1; // [RQ13]
                    {m_sda, m_scl, is_mst, trst, transmit_full} <= 5'h00;
                    mst <= M_IDLE;
                  end
                end
                default:
                begin
                  m_scl <= 1'b1;
                  mbit <= mbit + 4'd1;
                  if (mbit == mlast)
                  begin
                    mst <= M_IDLE;
                    m_sda <= 1'b0;
                    if (mmode == MD_TX)
                    begin
                      ackst <= msh[0]; // [RQ11]
                      trst <= 1'b0; // [RQ12]
                      transmit_full <= 1'b0; // [RQ21]
                    end
                    else if (mmode == MD_RX)
                    begin
                      con[`I2CC_RXE] <= 1'b0; // [RQ7]
                      if (receive_full)
                        rov <= 1'b1; // [RQ17]
                      else
                      begin
                        rcv <= msh;
                        receive_full <= 1'b1; // [RQ21]
                      end
                    end
                    else
                      con[`I2CC_AKS] <= 1'b0; // [RQ6]
                  end
                end
              endcase
            default: mst <= M_IDLE;
          endcase
        end
        if (is_mst)
          sst <= S_IDLE;
        else if (start_det)
        begin
          sst <= S_ADDR;
          bcnt <= 4'd0;
          s_sda <= 1'b0;
        end
        else if (stop_det)
        begin
          sst <= S_IDLE;
          s_sda <= 1'b0;
        end
        else if (s_rise)
        begin
          if (sst == S_ADDR || sst == S_ADR2 || sst == S_RX)
          begin
            rsr <= {rsr[6:0], sda_s};
            bcnt <= bcnt + 4'd1;
          end
          else if (sst == S_TX)
          begin
            bcnt <= bcnt + 4'd1;
            if (bcnt == 4'd8)
              mack <= sda_s;
          end
        end
        else if (s_fall)
          case (sst)
            S_ADDR, S_ADR2, S_RX:
              if (bcnt == 4'd8)
              begin
                bcnt <= 4'd0;
                sst <= S_ACK;
                snext <= S_RX;
                if (sst == S_ADDR)
                begin
                  if (adr_ok)
                  begin
                    s_sda <= 1'b1; // [RQ3]
                    d_a <= 1'b0; // [RQ18]
                    r_w <= rsr[0]; // [RQ19]
                    if (gc_hit)
                      gcst <= 1'b1; // [RQ14]
                    if (rsr[0])
                      snext <= S_TX;
                    else if (hdr10 & ~con[`I2CC_ACC])
                      snext <= S_ADR2; // [RQ4]
                  end
                  else
                    sst <= S_IDLE;
                end
                else if (sst == S_ADR2)
                begin
                  if (hit10)
                  begin
                    s_sda <= 1'b1;
                    ten_bit_match <= 1'b1; // [RQ15]
                    d_a <= 1'b0; // [RQ18]
                  end
                  else
                    sst <= S_IDLE;
                end
                else
                begin
                  d_a <= 1'b1; // [RQ18]
                  s_sda <= ~receive_full;
                  if (receive_full)
                    rov <= 1'b1; // [RQ17]
                  else
                  begin
                    rcv <= rsr;
                    receive_full <= 1'b1; // [RQ21]
                  end
                end
              end
            S_ACK:
            begin
              s_sda <= 1'b0;
              sst <= snext;
              if (snext == S_TX)
                con[`I2CC_REL] <= 1'b0; // [RQ2]
            end
            S_TX:
              if (bcnt == 4'd8)
                transmit_full <= 1'b0; // [RQ21]
              else if (bcnt == 4'd9)
              begin
                bcnt <= 4'd0;
                if (mack)
                  sst <= S_IDLE;
                else
                  con[`I2CC_REL] <= 1'b0; // [RQ2]
              end
            default: sst <= S_IDLE;
          endcase
        // Data changes only while the clock is low
        if (sst == S_TX && ~scl_s)
          s_sda <= (bcnt < 4'd8) & ~trn[3'd7 - bcnt[2:0]];
        s_scl <= ~con[`I2CC_REL] & (sst != S_IDLE) & (sst != S_ADDR) &
                 (~scl_s | s_scl); // [RQ1]
      end
      if (wr)
        case (paddr_i)
          `I2CC_CON:
          begin
            con <= pwdata_i[15:0] & `I2CC_CON_WMASK;
            // Without stretching a zero write to release is ignored
            con[`I2CC_REL] <= pwdata_i[`I2CC_STR] ? pwdata_i[`I2CC_REL] :
                              (pwdata_i[`I2CC_REL] | con[`I2CC_REL]); // [RQ2]
          end
          `I2CC_MSK: msk <= pwdata_i[9:0];
          `I2CC_ADD: own <= pwdata_i[9:0];
          `I2CC_BRG: brg <= pwdata_i[15:0];
          `I2CC_TRN:
            if (busy)
              write_collision <= 1'b1; // [RQ16]
            else
            begin
              trn <= pwdata_i[7:0];
              transmit_full <= 1'b1; // [RQ21]
              if (is_mst)
              begin
                mst <= M_BIT;
                mmode <= MD_TX;
                msh <= pwdata_i[7:0];
                trst <= 1'b1; // [RQ12]
              end
            end
          default: ;
        endcase
    end
  end
endmodule
`default_nettype wire

/* dv/i2cc_assertions.sv */
`default_nettype none
module i2cc_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cw;
  assign cw = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // Master sequences seen on the wires, and the unmapped-address error
  // ----
  a_start_made: assert property (
    cw && pwdata_i[15] && pwdata_i[0] && sda_i && scl_i
    |-> ##[1:300] $fell(sda_i) && scl_i)
    else $error("no start after request");
  a_start_shape: assert property (
    $rose(sda_oe_o) && scl_i
    |-> sda_oe_o throughout (##[1:300] $rose(scl_oe_o)))
    else $error("start not followed by clock low");
  a_restart_made: assert property (
    cw && pwdata_i[1] |-> ##[1:300] $fell(sda_i) && scl_i)
    else $error("no repeated start after request");
  a_stop_made: assert property (
    cw && pwdata_i[2] |-> ##[1:300] $rose(sda_i) && scl_i)
    else $error("no stop after request");
  a_ack_driven: assert property (
    cw && pwdata_i[4] && !pwdata_i[5]
    |-> ##[1:300] scl_i && sda_oe_o)
    else $error("ack value not driven");
  a_rx_releases: assert property (
    cw && pwdata_i[3] |-> ##5 !sda_oe_o [*8])
    else $error("data line driven during receive");
  a_start_refused: assert property (
    cw && pwdata_i[0] && !sda_i |-> ##1 !sda_oe_o [*8])
    else $error("start driven on a busy line");
  a_unmapped_err: assert property (
    psel_i && penable_i && paddr_i > 8'h18 |-> pslverr_o)
    else $error("unmapped access without error");
endmodule
bind i2cc_ctrl i2cc_assertions u_chk (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .scl_i(scl_i),
  .scl_o(scl_o),
  .scl_oe_o(scl_oe_o),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o)
);
`default_nettype wire

/* dv/i2cc_bus_peer.sv */
`default_nettype none
module i2cc_bus_peer (
  input wire logic mclk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_i,
  input wire logic [7:0] data_i,
  output var logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Target on the far side: acks bytes, serves data on reads
  // ----
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic rd = 1'b0;
  logic first = 1'b1;
  logic [3:0] cnt = 4'hf;
  logic [3:0] nx;
  assign nx = (cnt == 4'h8 || cnt == 4'hf) ? 4'h0 : cnt + 4'h1;
  initial sda_oe_o = 1'b0;
  always @(posedge mclk_i)
  begin
    ps <= scl_i;
    pd <= sda_i;
    if (scl_i && ps && pd != sda_i)
    begin
      // Start or Stop: the start's own clock fall must not count
      cnt <= 4'hf;
      first <= 1'b1;
      rd <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (!ps && scl_i)
    begin
      if (first && cnt == 4'h7)
        rd <= sda_i;
      if (!first && cnt == 4'h8 && rd)
        rd <= !sda_i;
    end
    else if (ps && !scl_i)
    begin
      cnt <= nx;
      if (cnt == 4'h8)
        first <= 1'b0;
      if (nx == 4'h8)
        sda_oe_o <= ack_i && (first || !rd);
      else
        sda_oe_o <= rd && !(first && cnt != 4'h8)
          && !data_i[3'h7 - nx[2:0]];
    end
  end
endmodule
`default_nettype wire

/* dv/i2cc_tb_top.sv */
`default_nettype none
module i2c_master_slave_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic [31:0] q;
  logic pready_o, pslverr_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic peer_oe, err;
  logic jam = 1'b0;
  logic tscl = 1'b0;
  logic tsda = 1'b0;
  logic a0, a1;
  logic ack = 1'b1;
  logic [7:0] pdata = 8'h3c;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  // Pull-ups: a released line reads high
  wire scl = !(scl_oe_o || tscl);
  wire sda = !(sda_oe_o || peer_oe || jam || tsda);
  always #5 mclk_i = ~mclk_i;
  i2cc_ctrl i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );
  i2cc_bus_peer i_peer (
    .mclk_i(mclk_i), .scl_i(scl), .sda_i(sda), .ack_i(ack),
    .data_i(pdata), .sda_oe_o(peer_oe)
  );
  // ----
  // Bus tasks
  // ----
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    // Only the bench timeout ends a wait for the slave's answer
    while (pready_o !== 1'b1)
      @(posedge mclk_i);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m,
    input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, {16'h0, e});
  endtask
  // Bounded wait for a self-clearing bit
  task automatic poll(input logic [7:0] a, input logic [15:0] m);
    int n;
    n = 0;
    q = m;
    while ((q & m) !== 32'h0 && n < 300)
    begin
      xfer(1'b0, a, 32'h0);
      n++;
    end
    chk(q & m, 32'h0);
  endtask
  // Far-side master: one bit per 80 ns link clock period
  task automatic far_bit(input logic b, output logic s);
    tsda <= !b;
    repeat (2) @(posedge mclk_i);
    tscl <= 1'b0;
    @(posedge mclk_i);
    // A stretching slave holds the clock low
    while (!scl)
      @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
    s = sda;
    tscl <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic far_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
      far_bit(b[i], s);
    far_bit(1'b1, a);
  endtask
  task automatic far_frame(input logic [7:0] adr, input logic [7:0] dat,
    output logic an, output logic dn);
    dn = 1'b1;
    tsda <= 1'b1;
    repeat (4) @(posedge mclk_i);
    tscl <= 1'b1;
    repeat (2) @(posedge mclk_i);
    far_byte(adr, an);
    if (!an)
      far_byte(dat, dn);
    tsda <= 1'b1;
    repeat (2) @(posedge mclk_i);
    tscl <= 1'b0;
    repeat (4) @(posedge mclk_i);
    tsda <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rchk(8'h00, 16'hffff, 16'h1000);
    rchk(8'h04, 16'hffff, 16'h0);
    rchk(8'h1c, 16'hffff, 16'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, 8'h08, 32'hffff);
    rchk(8'h08, 16'hffff, 16'h03ff);
    xfer(1'b1, 8'h18, 32'h1);
    xfer(1'b1, 8'h00, 32'h9000);
    xfer(1'b1, 8'h00, 32'h9001);
    poll(8'h00, 16'h1);
    rchk(8'h04, 16'h18, 16'h8);
    xfer(1'b1, 8'h0c, 32'ha0);
    rchk(8'h04, 16'h4001, 16'h4001);
    xfer(1'b1, 8'h0c, 32'h55);
    rchk(8'h04, 16'h80, 16'h80);
    poll(8'h04, 16'h4000);
    rchk(8'h04, 16'h8001, 16'h0);
    ack <= 1'b0;
    xfer(1'b1, 8'h0c, 32'h55);
    poll(8'h04, 16'h4000);
    rchk(8'h04, 16'h8000, 16'h8000);
    ack <= 1'b1;
    xfer(1'b1, 8'h00, 32'h9002);
    poll(8'h00, 16'h2);
    xfer(1'b1, 8'h0c, 32'ha1);
    poll(8'h04, 16'h4000);
    rchk(8'h04, 16'h8000, 16'h0);
    xfer(1'b1, 8'h00, 32'h9008);
    poll(8'h00, 16'h8);
    rchk(8'h04, 16'h2, 16'h2);
    rchk(8'h10, 16'hff, 16'h3c);
    rchk(8'h04, 16'h2, 16'h0);
    pdata <= 8'h5a;
    xfer(1'b1, 8'h00, 32'h9010);
    poll(8'h00, 16'h10);
    xfer(1'b1, 8'h00, 32'h9008);
    poll(8'h00, 16'h8);
    pdata <= 8'h81;
    xfer(1'b1, 8'h00, 32'h9010);
    poll(8'h00, 16'h10);
    // Third byte arrives with the second still unread
    xfer(1'b1, 8'h00, 32'h9008);
    poll(8'h00, 16'h8);
    rchk(8'h04, 16'h42, 16'h42);
    rchk(8'h10, 16'hff, 16'h5a);
    xfer(1'b1, 8'h00, 32'h9030);
    poll(8'h00, 16'h10);
    xfer(1'b1, 8'h00, 32'h9004);
    poll(8'h00, 16'h4);
    rchk(8'h04, 16'h18, 16'h10);
    xfer(1'b1, 8'h04, 32'h0);
    rchk(8'h04, 16'hc0, 16'h0);
    jam <= 1'b1;
    xfer(1'b1, 8'h00, 32'h9001);
    poll(8'h00, 16'h1);
    jam <= 1'b0;
    repeat (20) @(posedge mclk_i);
    rchk(8'h04, 16'h400, 16'h400);
    xfer(1'b1, 8'h04, 32'h0);
    rchk(8'h04, 16'h400, 16'h0);
    // Bench as far-side master, block addressed as a slave
    ack <= 1'b0;
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h14, 32'h52);
    far_frame(8'ha0, 8'h3c, a0, a1);
    chk({31'h0, a0}, 32'h1);
    xfer(1'b1, 8'h08, 32'h2);
    far_frame(8'ha0, 8'h3c, a0, a1);
    chk({30'h0, a0, a1}, 32'h0);
    rchk(8'h04, 16'h36, 16'h32);
    rchk(8'h10, 16'hff, 16'h3c);
    tally_and_finish();
  end
endmodule
`default_nettype wire
